// ---- rtl/fdn_datapath.v ----
// Decided for this implementation: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "fdn_regs.vh"
`default_nettype none

module fdn_datapath (
  // Clock, reset and clock enable.
  input wire clk_in,
  input wire rst_n_in,
  input wire ce_in,
  // Host processor data path.
  input wire [15:0] processor_output_bus_in,
  input wire first_timing_pulse_in,
  input wire third_timing_pulse_in,
  input wire abort_in,
  output reg [15:0] read_bus_out,
  output wire read_bus_en_out,
  // Status word transfer and result store.
  output reg psw_load_out,
  output reg [3:0] psw_codes_out,
  output reg psw_clk_inhibit_out,
  output reg store_valid_out,
  output reg [15:0] store_hi_out,
  output reg [15:0] store_lo_out,
  // Avalon-MM slave.
  input wire [4:0] avs_address_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire [31:0] avs_writedata_in,
  output reg [31:0] avs_readdata_out,
  output wire avs_waitrequest_out
);

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  localparam [3:0] S_IDLE = 4'h0;
  localparam [3:0] S_DCHK = 4'h1;
  localparam [3:0] S_DFIRST = 4'h2;
  localparam [3:0] S_DLOOP = 4'h3;
  localparam [3:0] S_NORM = 4'h4;
  localparam [3:0] S_ROUND = 4'h5;
  localparam [3:0] S_ASM = 4'h6;
  localparam [3:0] S_CHECK = 4'h7;
  localparam [3:0] S_STORE = 4'h8;
  localparam [3:0] S_XFER = 4'h9;

  // ----------------------------------------------------------------
  // Shared four-way selector
  // ----------------------------------------------------------------
  // Both read selectors use the same port ordering.
  function [15:0] fdn_mux4;
    input [1:0] sel;
    input [15:0] p0;
    input [15:0] p1;
    input [15:0] p2;
    input [15:0] p3;
    begin
      case (sel)
        2'h0: fdn_mux4 = p0;
        2'h1: fdn_mux4 = p1;
        2'h2: fdn_mux4 = p2;
        default: fdn_mux4 = p3;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  reg [2:0] p1_sync_r; // Synchroniser for the first pulse.
  reg [2:0] p3_sync_r; // Synchroniser for the third pulse.
  reg p1_lvl_r; // Accepted level of the first pulse.
  reg p3_lvl_r; // Accepted level of the third pulse.
  reg [15:0] bus1_r; // Bus pipeline, stage one.
  reg [15:0] bus2_r; // Bus pipeline, stage two.
  reg [15:0] bus3_r; // Bus pipeline, stage three.
  reg [15:0] input_holding_reg_r; // Sole entry point for data.
  reg [15:0] low_shift_reg_r; // Quotient and mantissa high part.
  reg [15:0] mid_float_shift_reg_r; // Quotient low part.
  reg [15:0] high_float_shift_reg_r; // Dividend sign and exponent.
  reg [7:0] step_cnt_r; // Loop step counter.
  reg [25:0] divisor_r; // Divisor mantissa.
  reg [7:0] divisor_exp_r; // Divisor exponent.
  reg divisor_sign_r; // Divisor sign.
  reg [27:0] rem_r; // Signed partial remainder.
  reg [9:0] exp_r; // Signed working exponent.
  reg sign_r; // Sign of the answer.
  reg [3:0] local_condition_codes_r; // N, Z, V, C.
  reg held_r; // Codes held after an abort.
  reg done_r; // Last instruction completed.
  reg [3:0] state_r; // Sequencer state.
  reg [3:0] rsel_r; // Read selector control.
  reg ack_r; // Bus answer phase.
  wire p1_rise; // First pulse accepted.
  wire p3_rise; // Third pulse accepted.
  wire [25:0] quo; // Quotient as one word.
  wire quotient_lsb; // Lowest quotient bit.
  wire mantissa_top_bit; // Normalized marker.
  wire do_sub; // Subtract rather than add back.
  wire [27:0] alu; // Divide step adder.
  wire step_carry; // Carry-out of the step.
  wire [25:0] rnd; // Rounded mantissa.
  wire [15:0] integer_read_selector; // Integer selector output.
  wire [15:0] float_read_selector; // Float selector output.
  wire exp_ovf; // Exponent above range.
  wire exp_unf; // Exponent at or below zero.
  wire busy; // Sequencer running.
  wire cmd_wr; // Accepted command write.
  reg [31:0] rd_val; // Read data before the register.
  wire [15:0] exp_bias = `FDN_EXP_BIAS;

  // ----------------------------------------------------------------
  // Timing pulse synchronisers
  // ----------------------------------------------------------------
  // A pulse counts only once stages two and three agree, so a
  // glitch shorter than a clock never loads the holding register.
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      p1_sync_r <= 3'h0;
      p3_sync_r <= 3'h0;
      p1_lvl_r <= 1'b0;
      p3_lvl_r <= 1'b0;
      bus1_r <= 16'h0000;
      bus2_r <= 16'h0000;
      bus3_r <= 16'h0000;
    end else if (ce_in) begin
      p1_sync_r <= {p1_sync_r[1:0], first_timing_pulse_in};
      p3_sync_r <= {p3_sync_r[1:0], third_timing_pulse_in};
      bus1_r <= processor_output_bus_in;
      bus2_r <= bus1_r;
      bus3_r <= bus2_r;
      // Accepted levels follow only agreeing stages.
      if (p1_sync_r[1] == p1_sync_r[2]) begin
        p1_lvl_r <= p1_sync_r[2];
      end
      if (p3_sync_r[1] == p3_sync_r[2]) begin
        p3_lvl_r <= p3_sync_r[2];
      end
    end
  end

  assign p1_rise = p1_sync_r[1] & p1_sync_r[2] & ~p1_lvl_r;
  assign p3_rise = p3_sync_r[1] & p3_sync_r[2] & ~p3_lvl_r;

  // ----------------------------------------------------------------
  // Combinational datapath
  // ----------------------------------------------------------------
  assign quo = {low_shift_reg_r[9:0], mid_float_shift_reg_r};
  assign quotient_lsb = mid_float_shift_reg_r[0];
  assign mantissa_top_bit = low_shift_reg_r[`FDN_MANT_TOP];
  // First step always subtracts; later steps follow the last bit.
  assign do_sub = (state_r == S_DFIRST) | quotient_lsb;
  assign alu = do_sub ? (rem_r - {2'b00, divisor_r})
                      : (rem_r + {2'b00, divisor_r});
  assign step_carry = ~alu[27];
  assign rnd = {1'b0, quo[25:1]} + 26'h0000001;
  assign exp_ovf = ~exp_r[9] & exp_r[8];
  assign exp_unf = exp_r[9] | (exp_r == 10'h000);
  assign busy = (state_r != S_IDLE);

  // Integer port order: codes, low register, concatenated, holding.
  assign integer_read_selector = fdn_mux4(rsel_r[1:0],
    {12'h000, local_condition_codes_r}, low_shift_reg_r,
    {input_holding_reg_r[14:0], low_shift_reg_r[15]},
    input_holding_reg_r);
  // Float ports: high, mid, exponent offset, assembled word.
  assign float_read_selector = fdn_mux4(rsel_r[1:0],
    high_float_shift_reg_r, mid_float_shift_reg_r, exp_bias,
    {local_condition_codes_r[3], input_holding_reg_r[7:0],
     low_shift_reg_r[6:0]});
  assign read_bus_en_out = rsel_r[`FDN_RSEL_EN];

  // ----------------------------------------------------------------
  // Avalon-MM slave handshake
  // ----------------------------------------------------------------
  // Every access waits exactly one cycle; this keeps read data
  // registered without a combinational path from the address.
  assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_r;
  assign cmd_wr = avs_write_in & ack_r &
                  (avs_address_in == `FDN_OFS_CMD);

  // Read data decode; unmapped addresses return zero.
  always @* begin
    rd_val = 32'h00000000;
    if (avs_address_in == `FDN_OFS_HOLD) begin
      rd_val = {16'h0000, input_holding_reg_r};
    end else if (avs_address_in == `FDN_OFS_RSEL) begin
      rd_val = {28'h0000000, rsel_r};
    end else if (avs_address_in == `FDN_OFS_STAT) begin
      rd_val = {24'h000000, local_condition_codes_r, 1'b0,
                held_r, done_r, busy};
    end else if (avs_address_in == `FDN_OFS_RBUS) begin
      rd_val = {16'h0000, read_bus_out};
    end else if (avs_address_in == `FDN_OFS_CNT) begin
      rd_val = {24'h000000, step_cnt_r};
    end
  end

  // Answer phase, read data and read selector control register.
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      ack_r <= 1'b0;
      avs_readdata_out <= 32'h00000000;
      rsel_r <= `FDN_RSEL_RST;
      read_bus_out <= 16'h0000;
    end else if (ce_in) begin
      ack_r <= (avs_read_in | avs_write_in) & ~ack_r;
      if (avs_read_in & ~ack_r) begin
        avs_readdata_out <= rd_val;
      end
      if (avs_write_in & ack_r &
          (avs_address_in == `FDN_OFS_RSEL)) begin
        rsel_r <= avs_writedata_in[3:0];
      end
      // The float selector owns the bus only in float mode.
      if (rsel_r[`FDN_RSEL_FLT]) begin
        read_bus_out <= float_read_selector;
      end else begin
        read_bus_out <= integer_read_selector;
      end
    end
  end

  // ----------------------------------------------------------------
  // Holding register
  // ----------------------------------------------------------------
  // The bus word is delayed to match the pulse synchroniser.
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      input_holding_reg_r <= 16'h0000;
    end else if (ce_in) begin
      if (p1_rise | p3_rise) begin
        input_holding_reg_r <= bus3_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequencer and datapath registers
  // ----------------------------------------------------------------
  // The state code selects every load, shift and count below, in
  // place of a stored microword per step.
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_r <= S_IDLE;
      low_shift_reg_r <= 16'h0000;
      mid_float_shift_reg_r <= 16'h0000;
      high_float_shift_reg_r <= 16'h0000;
      step_cnt_r <= 8'h00;
      divisor_r <= 26'h0000000;
      divisor_exp_r <= 8'h00;
      divisor_sign_r <= 1'b0;
      rem_r <= 28'h0000000;
      exp_r <= 10'h000;
      sign_r <= 1'b0;
      local_condition_codes_r <= 4'h0;
      held_r <= 1'b0;
      done_r <= 1'b0;
      psw_load_out <= 1'b0;
      psw_codes_out <= 4'h0;
      psw_clk_inhibit_out <= 1'b0;
      store_valid_out <= 1'b0;
      store_hi_out <= 16'h0000;
      store_lo_out <= 16'h0000;
    end else if (ce_in) begin
      psw_load_out <= 1'b0;
      psw_clk_inhibit_out <= 1'b0;
      store_valid_out <= 1'b0;
      if (busy & abort_in) begin
        // Codes stay here; the host status is left alone.
        held_r <= 1'b1;
        state_r <= S_IDLE;
      end else begin
        case (state_r)
          S_IDLE: begin
            // Loads come only through the holding register.
            if (cmd_wr) begin
              case (avs_writedata_in[3:0])
                `FDN_CMD_LD_LOW: begin
                  low_shift_reg_r <= input_holding_reg_r;
                end
                `FDN_CMD_LD_MID: begin
                  mid_float_shift_reg_r <= input_holding_reg_r;
                end
                `FDN_CMD_LD_HIGH: begin
                  high_float_shift_reg_r <= input_holding_reg_r;
                end
                `FDN_CMD_LD_DSRH: begin
                  divisor_r[25:16] <= input_holding_reg_r[9:0];
                  divisor_sign_r <= input_holding_reg_r[15];
                end
                `FDN_CMD_LD_DSRL: begin
                  divisor_r[15:0] <= input_holding_reg_r;
                end
                `FDN_CMD_LD_DEXP: begin
                  divisor_exp_r <= input_holding_reg_r[7:0];
                end
                `FDN_CMD_LD_CNT: begin
                  step_cnt_r <= input_holding_reg_r[7:0];
                end
                `FDN_CMD_START: begin
                  done_r <= 1'b0;
                  state_r <= S_DCHK;
                end
                `FDN_CMD_CLR_HELD: begin
                  held_r <= 1'b0;
                end
                default: begin
                  held_r <= held_r;
                end
              endcase
            end
          end
          S_DCHK: begin
            if (divisor_r == 26'h0000000) begin
              // Divide by zero reports underflow and stores nothing.
              local_condition_codes_r <= 4'h3;
              state_r <= S_XFER;
            end else if (quo == 26'h0000000) begin
              // Clean zero answer goes straight to the store.
              sign_r <= 1'b0;
              store_hi_out <= 16'h0000;
              store_lo_out <= 16'h0000;
              local_condition_codes_r <= 4'h4;
              state_r <= S_STORE;
            end else begin
              sign_r <= high_float_shift_reg_r[15] ^ divisor_sign_r;
              exp_r <= {2'b00, high_float_shift_reg_r[7:0]} -
                       {2'b00, divisor_exp_r} + exp_bias[9:0];
              step_cnt_r <= `FDN_STEP_LOAD;
              rem_r <= {2'b00, quo};
              low_shift_reg_r <= 16'h0000;
              mid_float_shift_reg_r <= 16'h0000;
              state_r <= S_DFIRST;
            end
          end
          S_DFIRST: begin
            rem_r <= {alu[26:0], 1'b0};
            {low_shift_reg_r[9:0], mid_float_shift_reg_r} <=
              {quo[24:0], step_carry};
            step_cnt_r <= step_cnt_r - 8'h01;
            state_r <= S_DLOOP;
          end
          S_DLOOP: begin
            if (step_cnt_r == 8'h00) begin
              state_r <= S_NORM;
            end else begin
              rem_r <= {alu[26:0], 1'b0};
              {low_shift_reg_r[9:0], mid_float_shift_reg_r} <=
                {quo[24:0], step_carry};
              step_cnt_r <= step_cnt_r - 8'h01;
            end
          end
          S_NORM: begin
            if (mantissa_top_bit) begin
              state_r <= S_ROUND;
            end else begin
              {low_shift_reg_r[9:0], mid_float_shift_reg_r} <=
                {quo[24:0], 1'b0};
              exp_r <= exp_r - 10'h001;
            end
          end
          S_ROUND: begin
            if (rnd[25]) begin
              // Carry ran past the top: renormalize right.
              {low_shift_reg_r[9:0], mid_float_shift_reg_r} <=
                {rnd[25:2], 2'b00};
              exp_r <= exp_r + 10'h001;
            end else begin
              // Guard position is cleared, never stored.
              {low_shift_reg_r[9:0], mid_float_shift_reg_r} <=
                {rnd[24:1], 2'b00};
            end
            state_r <= S_ASM;
          end
          S_ASM: begin
            // Hidden one at quotient bit 25 is left out.
            store_hi_out <= {sign_r, exp_r[7:0], quo[24:18]};
            store_lo_out <= quo[17:2];
            state_r <= S_CHECK;
          end
          S_CHECK: begin
            if (exp_ovf) begin
              local_condition_codes_r <= {sign_r, 3'h2};
              state_r <= S_XFER;
            end else if (exp_unf) begin
              local_condition_codes_r <= {sign_r, 3'h3};
              state_r <= S_XFER;
            end else begin
              local_condition_codes_r <= {sign_r, 3'h0};
              state_r <= S_STORE;
            end
          end
          S_STORE: begin
            store_valid_out <= 1'b1;
            state_r <= S_XFER;
          end
          S_XFER: begin
            // Inhibit keeps the host's other status bits frozen.
            psw_load_out <= 1'b1;
            psw_codes_out <= local_condition_codes_r;
            psw_clk_inhibit_out <= 1'b1;
            done_r <= 1'b1;
            state_r <= S_IDLE;
          end
          default: begin
            state_r <= S_IDLE;
          end
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// ---- rtl/fdn_regs.vh ----
`ifndef FDN_REGS_VH
`define FDN_REGS_VH

// ----------------------------------------------------------------
// Register byte offsets on the Avalon slave
// ----------------------------------------------------------------
`define FDN_OFS_HOLD 5'h00
`define FDN_OFS_CMD 5'h04
`define FDN_OFS_RSEL 5'h08
`define FDN_OFS_STAT 5'h0C
`define FDN_OFS_RBUS 5'h10
`define FDN_OFS_CNT 5'h14

// ----------------------------------------------------------------
// Command codes written to the command register, bits 3:0
// ----------------------------------------------------------------
`define FDN_CMD_LD_LOW 4'h0
`define FDN_CMD_LD_MID 4'h1
`define FDN_CMD_LD_HIGH 4'h2
`define FDN_CMD_LD_DSRH 4'h3
`define FDN_CMD_LD_DSRL 4'h4
`define FDN_CMD_LD_DEXP 4'h5
`define FDN_CMD_LD_CNT 4'h6
`define FDN_CMD_START 4'h8
`define FDN_CMD_CLR_HELD 4'h9

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define FDN_RSEL_FLT 2
`define FDN_RSEL_EN 3
`define FDN_RSEL_RST 4'h0
`define FDN_ST_BUSY 0
`define FDN_ST_DONE 1
`define FDN_ST_HELD 2
`define FDN_ST_CC_LSB 4
`define FDN_MANT_TOP 9

// ----------------------------------------------------------------
// Constants of the arithmetic
// ----------------------------------------------------------------
`define FDN_EXP_BIAS 16'h0080
`define FDN_STEP_LOAD 8'h18

`endif

// ---- testbench/fdn_host.sv ----
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Host processor side: output bus and timing pulses
// ----------------------------------------------------------------
module fdn_host (
  // Clock.
  input wire logic clk_in,
  // Output bus and pulses toward the option.
  output logic [15:0] bus_out,
  output logic p1_out,
  output logic p3_out
);
  // Quiet bus and pulses at time zero.
  initial begin
    bus_out = 16'h0000;
    p1_out = 1'b0;
    p3_out = 1'b0;
  end

  // One word per pulse; the bus is settled well before the pulse and kept
  // after it, then scrambled so a late capture cannot pass.
  task send(input logic [15:0] d, input logic third);
    begin
      @(posedge clk_in);
      bus_out <= d;
      repeat (2) @(posedge clk_in);
      if (third) begin
        p3_out <= 1'b1;
      end else begin
        p1_out <= 1'b1;
      end
      repeat (3) @(posedge clk_in);
      p1_out <= 1'b0;
      p3_out <= 1'b0;
      repeat (3) @(posedge clk_in);
      bus_out <= ~d;
      repeat (2) @(posedge clk_in);
    end
  endtask
endmodule

`default_nettype wire

// ---- testbench/fdn_datapath_sva.sv ----
`timescale 1ns/1ps
`include "fdn_regs.vh"
`default_nettype none

// ----------------------------------------------------------------
// Port checker of the divide and normalize datapath
// ----------------------------------------------------------------
module fdn_datapath_sva (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Avalon slave.
  input wire logic [4:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic avs_waitrequest_out,
  // Results toward the host.
  input wire logic read_bus_en_out,
  input wire logic psw_load_out,
  input wire logic [3:0] psw_codes_out,
  input wire logic psw_clk_inhibit_out,
  input wire logic store_valid_out,
  input wire logic [15:0] store_hi_out,
  input wire logic [15:0] store_lo_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  // Steps of a request and of a finished instruction.
  sequence s_req_wait;
    (avs_read_in || avs_write_in) && avs_waitrequest_out;
  endsequence
  sequence s_store;
    store_valid_out;
  endsequence
  sequence s_xfer;
    psw_load_out && psw_clk_inhibit_out;
  endsequence

  a_wait_one_cycle: assert property (s_req_wait |=> !avs_waitrequest_out)
    else $error("waitrequest held longer than one cycle");
  a_idle_no_wait: assert property (!(avs_read_in || avs_write_in) |-> !avs_waitrequest_out)
    else $error("waitrequest without a request");
  a_inhibit_pair: assert property (psw_load_out == psw_clk_inhibit_out)
    else $error("status inhibit not paired with transfer");
  a_xfer_pulse: assert property (s_xfer |=> !psw_load_out)
    else $error("status transfer longer than one cycle");
  a_store_then_xfer: assert property (s_store |=> s_xfer)
    else $error("store not followed by status transfer");
  a_codes_held: assert property (!psw_load_out |-> $stable(psw_codes_out))
    else $error("codes changed without a transfer");
  a_flag_no_store: assert property (psw_load_out && psw_codes_out[1] |->
    !$past(store_valid_out))
    else $error("result stored despite range fault");
  a_zero_codes: assert property (store_valid_out && store_hi_out == 16'h0000 &&
    store_lo_out == 16'h0000 |=> psw_codes_out == 4'h4)
    else $error("zero answer without zero codes");
  a_rsel_enable: assert property (avs_write_in && !avs_waitrequest_out &&
    avs_address_in == `FDN_OFS_RSEL |=>
    read_bus_en_out == $past(avs_writedata_in[`FDN_RSEL_EN]))
    else $error("read bus enable does not follow selector write");
endmodule

bind fdn_datapath fdn_datapath_sva i_sva (
  .clk_in(clk_in),
  .rst_n_in(rst_n_in),
  .avs_address_in(avs_address_in),
  .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in),
  .avs_writedata_in(avs_writedata_in),
  .avs_waitrequest_out(avs_waitrequest_out),
  .read_bus_en_out(read_bus_en_out),
  .psw_load_out(psw_load_out),
  .psw_codes_out(psw_codes_out),
  .psw_clk_inhibit_out(psw_clk_inhibit_out),
  .store_valid_out(store_valid_out),
  .store_hi_out(store_hi_out),
  .store_lo_out(store_lo_out)
);

`default_nettype wire

// ---- testbench/float_divide_normalize_datapath_tb.sv ----
`timescale 1ns/1ps
`include "fdn_regs.vh"
`default_nettype none

// ----------------------------------------------------------------
// Self-checking bench of the divide and normalize datapath
// ----------------------------------------------------------------
module float_divide_normalize_datapath_tb;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic abort_in = 1'b0;
  logic [4:0] avs_address_in = 5'h00;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h00000000;
  wire logic [15:0] bus;
  wire logic p1;
  wire logic p3;
  wire logic [15:0] read_bus_out;
  wire logic read_bus_en_out;
  wire logic psw_load_out;
  wire logic [3:0] psw_codes_out;
  wire logic psw_clk_inhibit_out;
  wire logic store_valid_out;
  wire logic [15:0] store_hi_out;
  wire logic [15:0] store_lo_out;
  wire logic [31:0] avs_readdata_out;
  wire logic avs_waitrequest_out;
  // Expected results; reads and stores kept as mask and value, status codes as value only.
  logic [63:0] rd_q[$];
  logic [3:0] psw_q[$];
  logic [63:0] st_q[$];
  logic [63:0] e;
  logic [15:0] r;
  logic [15:0] q;
  integer bad_count = 0;
  integer tests_run = 0;
  integer seed = 32'h32d8e894;
  integer cycles = 0;
  integer i;

  // 40 MHz clock.
  initial forever #12.5 clk_in = ~clk_in;

  fdn_host i_host (.clk_in(clk_in), .bus_out(bus), .p1_out(p1), .p3_out(p3));

  fdn_datapath i_dut (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(1'b1),
    .processor_output_bus_in(bus), .first_timing_pulse_in(p1),
    .third_timing_pulse_in(p3), .abort_in(abort_in),
    .read_bus_out(read_bus_out), .read_bus_en_out(read_bus_en_out),
    .psw_load_out(psw_load_out), .psw_codes_out(psw_codes_out),
    .psw_clk_inhibit_out(psw_clk_inhibit_out), .store_valid_out(store_valid_out),
    .store_hi_out(store_hi_out), .store_lo_out(store_lo_out),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out));

  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    begin
      tests_run++;
      if (seen !== exp) begin
        bad_count++;
        $display("FAIL %s expected %h seen %h", name, exp, seen);
      end
    end
  endtask

  task report_and_stop;
    begin
      if (bad_count == 0 && tests_run > 0) begin
        $display("No errors found");
      end else begin
        $display("Errors were found");
      end
      $finish;
    end
  endtask

  // Avalon cycle: request held until waitrequest is seen low.
  task av(input logic w, input logic [4:0] a, input logic [31:0] d,
          input logic [31:0] m, input logic [31:0] x);
    begin
      if (!w) rd_q.push_back({m, x});
      @(posedge clk_in);
      avs_address_in <= a;
      avs_writedata_in <= d;
      if (w) avs_write_in <= 1'b1;
      else avs_read_in <= 1'b1;
      @(posedge clk_in);
      while (avs_waitrequest_out !== 1'b0) @(posedge clk_in);
      avs_write_in <= 1'b0;
      avs_read_in <= 1'b0;
    end
  endtask

  task cmd(input logic [3:0] c);
    av(1'b1, `FDN_OFS_CMD, {28'h0000000, c}, 32'h0, 32'h0);
  endtask

  // Word through the holding register, then into the register named by c.
  task load(input logic [15:0] v, input logic [3:0] c);
    begin
      i_host.send(v, c[0]);
      cmd(c);
    end
  endtask

  task setup(input logic [15:0] a0, a1, a2, a3, a4, a5);
    begin
      load(a0, `FDN_CMD_LD_LOW);
      load(a1, `FDN_CMD_LD_MID);
      load(a2, `FDN_CMD_LD_HIGH);
      load(a3, `FDN_CMD_LD_DSRH);
      load(a4, `FDN_CMD_LD_DSRL);
      load(a5, `FDN_CMD_LD_DEXP);
    end
  endtask

  // Start a divide; wait, bounded, for the transfer.
  task run;
    begin
      cmd(`FDN_CMD_START);
      for (i = 0; i < 600 && psw_load_out !== 1'b1; i++) @(posedge clk_in);
      repeat (2) @(posedge clk_in);
    end
  endtask

  // Output watcher: each result takes the oldest note of its kind.
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      report_and_stop;
    end
    if (rst_n_in && avs_read_in && avs_waitrequest_out === 1'b0) begin
      e = rd_q.pop_front();
      chk("readdata", avs_readdata_out & e[63:32], e[31:0]);
    end
    if (rst_n_in && psw_load_out !== 1'b0) begin
      if (psw_q.size() == 0) chk("unexpected transfer", 32'h1, 32'h0);
      else chk("status codes", {28'h0, psw_codes_out}, {28'h0, psw_q.pop_front()});
    end
    if (rst_n_in && store_valid_out !== 1'b0) begin
      if (st_q.size() == 0) chk("unexpected store", 32'h1, 32'h0);
      else begin
        e = st_q.pop_front();
        chk("store", {store_hi_out, store_lo_out} & e[63:32], e[31:0]);
      end
    end
  end

  initial begin
    repeat (10) @(posedge clk_in);
    rst_n_in <= 1'b1;
    av(1'b0, `FDN_OFS_STAT, 32'h0, 32'hFF, 32'h0);
    av(1'b0, `FDN_OFS_RSEL, 32'h0, 32'hF, {28'h0, `FDN_RSEL_RST});
    av(1'b0, 5'h18, 32'h0, 32'hFFFFFFFF, 32'h0);
    // Holding register via both pulses, counter from its low byte.
    for (i = 0; i < 2; i++) begin
      r = $random(seed);
      i_host.send(r, i[0]);
      av(1'b0, `FDN_OFS_HOLD, 32'h0, 32'hFFFF, {16'h0, r});
    end
    cmd(`FDN_CMD_LD_CNT);
    av(1'b0, `FDN_OFS_CNT, 32'h0, 32'hFF, {24'h0, r[7:0]});
    // Read selectors: low register, holding register, exponent offset.
    load(~r, `FDN_CMD_LD_LOW);
    av(1'b1, `FDN_OFS_RSEL, 32'h9, 32'h0, 32'h0);
    repeat (3) @(posedge clk_in);
    chk("low port", {16'h0, read_bus_out}, {16'h0, ~r});
    chk("bus enable", {31'h0, read_bus_en_out}, 32'h1);
    av(1'b1, `FDN_OFS_RSEL, 32'hB, 32'h0, 32'h0);
    repeat (3) @(posedge clk_in);
    chk("hold port", {16'h0, read_bus_out}, {16'h0, ~r});
    av(1'b1, `FDN_OFS_RSEL, 32'hE, 32'h0, 32'h0);
    repeat (3) @(posedge clk_in);
    chk("offset port", {16'h0, read_bus_out}, 32'h0080);
    // Divide by zero: underflow codes, nothing stored.
    psw_q.push_back(4'h3);
    setup(16'h0200, 16'h0, 16'h0081, 16'h0, 16'h0, 16'h0);
    run;
    av(1'b0, `FDN_OFS_STAT, 32'h0, 32'hF7, 32'h32);
    // Zero dividend: zero answer stored, then zero codes.
    psw_q.push_back(4'h4);
    st_q.push_back({32'hFFFFFFFF, 32'h0});
    setup(16'h0, 16'h0, 16'h0, 16'h0200, 16'h0, 16'h0081);
    run;
    // Random normalized operands: sign of the answer is the sign XOR.
    for (int k = 0; k < 4; k++) begin
      r = $random(seed);
      q = $random(seed);
      psw_q.push_back({r[15] ^ q[15], 3'b000});
      st_q.push_back({32'h80000000, r[15] ^ q[15], 31'h0});
      setup(16'h0200 | r[8:0], q, {r[15], 7'h0, 8'h81},
            {q[15], 5'h0, 1'b1, r[8:0]}, r, 16'h0081);
      run;
    end
    // Exponent overflow and underflow: range codes, no store.
    psw_q.push_back(4'h2);
    setup(16'h0200, 16'h0, 16'h00FF, 16'h0200, 16'h0, 16'h0001);
    run;
    psw_q.push_back(4'h3);
    setup(16'h0200, 16'h0, 16'h0001, 16'h0200, 16'h0, 16'h00FF);
    run;
    // Abort mid-loop: no transfer, codes kept, held flag until cleared.
    cmd(`FDN_CMD_START);
    repeat (6) @(posedge clk_in);
    abort_in <= 1'b1;
    @(posedge clk_in);
    abort_in <= 1'b0;
    repeat (40) @(posedge clk_in);
    av(1'b0, `FDN_OFS_STAT, 32'h0, 32'hF5, 32'h34);
    cmd(`FDN_CMD_CLR_HELD);
    av(1'b0, `FDN_OFS_STAT, 32'h0, 32'h4, 32'h0);
    repeat (4) @(posedge clk_in);
    chk("pending results", psw_q.size() + st_q.size() + rd_q.size(), 32'h0);
    report_and_stop;
  end
endmodule

`default_nettype wire
